// >>> design/bsc_spinup.sv
// Speed command filter, start-up sequencer and phase PWM generator.
// Behaviour
// - three phases driven by fixed 25 kHz PWM.
// - lowest phase subtracted, one phase always zero.
// - peak amplitude maximal at full command duty.
// - input duty measured as 9-bit value 0..511.
// - command follows duty through 80 ms lowpass.
// - min duty code: none, 5, 10, 13 percent.
// - between 1.5 percent and floor, use floor.
// - below 1.5 percent stop driving, enter standby.
// - align holds U grounded, drives V and W.
// - align/open duty chosen from supply band.
// - open loop accelerates to hand-off frequency.
// - closed loop: external steps, command sets amplitude.
// - hand-off frequency is 12.5 Hz times code.
// - align 40n ms, accel 160-10n Hz/s.
// - direction pin picks U-V-W or U-W-V order.
// - start-up uses direction pin at that time.
`include "bsc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module bsc_spinup #(
  parameter int MS_CYCLES = `BSC_MS_CYCLES,
  parameter int SAMPLE_DIV = `BSC_SAMPLE_DIV
) (
  // Clock, reset and clock enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Register bus.
  input wire bsc_pkg::bsc_apb_req_s apb_req,
  output bsc_pkg::bsc_apb_rsp_s apb_rsp,
  // Pins from the host.
  input wire logic speed_pwm,
  input wire logic direction_select,
  // On-chip supply band and sensorless commutation step.
  input wire logic [2:0] vcc_band,
  input wire logic cl_step,
  // Motor phases.
  output bsc_pkg::bsc_phase_s phase_pwm,
  output logic phase_drive_en
);
  import bsc_pkg::*;

  localparam logic [10:0] PERIOD = 11'(`BSC_PWM_PERIOD);
  localparam logic [28:0] STEP_MAX = 29'(`BSC_STEP_ACC_MAX);
  localparam logic [6:0] STEPS = 7'(`BSC_STEPS);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] pwm_sync_q;
  logic [1:0] dir_sync_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_sync_q <= 2'h0;
      dir_sync_q <= 2'h0;
    end else if (clk_en) begin
      pwm_sync_q <= {pwm_sync_q[0], speed_pwm};
      dir_sync_q <= {dir_sync_q[0], direction_select};
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] cfg_q;
  logic [1:0] min_duty_code;
  logic [3:0] handoff_code;
  logic [3:0] align_accel_code;
  bsc_state_e state_q;
  logic dir_q;
  logic [8:0] cmd;
  logic [17:0] freq_q;
  logic [31:0] rdata_d;
  logic err_d;
  logic [31:0] prdata_q;
  logic pslverr_q;

  assign min_duty_code = cfg_q[`BSC_CFG_MIN_LSB +: 2];
  assign handoff_code = cfg_q[`BSC_CFG_HO_LSB +: 4];
  assign align_accel_code = cfg_q[`BSC_CFG_TA_LSB +: 4];

  always_comb begin
    rdata_d = 32'h0;
    err_d = 1'b0;
    if (apb_req.paddr == `BSC_OFF_CONFIG) begin
      rdata_d[11:0] = cfg_q[11:0];
    end else if (apb_req.paddr == `BSC_OFF_STATUS) begin
      rdata_d[8:0] = cmd;
      rdata_d[`BSC_ST_STATE_LSB +: 2] = state_q;
      rdata_d[`BSC_ST_DIR_BIT] = dir_q;
      err_d = apb_req.pwrite;
    end else if (apb_req.paddr == `BSC_OFF_FREQ) begin
      rdata_d[17:0] = freq_q;
      err_d = apb_req.pwrite;
    end else begin
      err_d = 1'b1;
    end
  end

  // Answer is decoded in the setup cycle so read data comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (clk_en && apb_req.psel && !apb_req.penable) begin
      prdata_q <= rdata_d;
      pslverr_q <= err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `BSC_CFG_RESET;
    end else if (clk_en && apb_req.psel && apb_req.penable &&
                 apb_req.pwrite && apb_req.paddr == `BSC_OFF_CONFIG) begin
      cfg_q <= {20'h0, apb_req.pwdata[11:0] & 12'hff3};
    end
  end

  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = pslverr_q;

  // ****************************************************************
  // Duty measurement and command filter
  // ****************************************************************
  logic [15:0] div_q;
  logic [8:0] samp_q;
  logic [9:0] high_q;
  logic [14:0] filt_q;
  logic samp_tick;
  logic [9:0] high_tot;
  logic [8:0] meas;

  assign samp_tick = (div_q == 16'(SAMPLE_DIV - 1));
  assign high_tot = high_q + {9'h0, pwm_sync_q[1]};
  assign meas = high_tot[9] ? 9'h1ff : high_tot[8:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0;
      samp_q <= 9'h0;
      high_q <= 10'h0;
    end else if (clk_en) begin
      div_q <= samp_tick ? 16'h0 : div_q + 16'h1;
      if (samp_tick) begin
        samp_q <= samp_q + 9'h1;
        high_q <= (samp_q == 9'h1ff) ? 10'h0 : high_tot;
      end
    end
  end

  // Time constant is 64 windows of 512 samples, about 80 ms.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= 15'h0;
    end else if (clk_en && samp_tick && samp_q == 9'h1ff) begin
      filt_q <= filt_q + {6'h0, meas} - {6'h0, filt_q[14:6]};
    end
  end

  assign cmd = filt_q[14:6];

  // ****************************************************************
  // Amplitude selection
  // ****************************************************************
  logic [8:0] floor_duty;
  logic [8:0] run_amp;
  logic [8:0] band_amp;
  logic standby_req;

  always_comb begin
    case (min_duty_code)
      2'h1: floor_duty = `BSC_MIN_5;
      2'h2: floor_duty = `BSC_MIN_10;
      2'h3: floor_duty = `BSC_MIN_13;
      default: floor_duty = 9'h0;
    endcase
    case (vcc_band)
      3'h1: band_amp = `BSC_OL_75;
      3'h2: band_amp = `BSC_OL_60;
      3'h3: band_amp = `BSC_OL_50;
      3'h4: band_amp = `BSC_OL_43;
      default: band_amp = `BSC_OL_100;
    endcase
  end

  assign standby_req = (cmd < `BSC_STBY_TH);
  assign run_amp = (cmd < floor_duty) ? floor_duty : cmd;

  // ****************************************************************
  // Start-up sequencer
  // ****************************************************************
  logic [15:0] ms_div_q;
  logic ms_tick;
  logic [9:0] ms_q;
  logic [3:0] n_ta;
  logic [3:0] n_ho;
  logic [9:0] align_ms;
  logic [7:0] accel;
  logic [17:0] handoff_mhz;

  // A code of zero is treated as one, the quickest setting.
  assign n_ta = (align_accel_code == 4'h0) ? 4'h1 : align_accel_code;
  assign n_ho = (handoff_code == 4'h0) ? 4'h1 : handoff_code;
  assign align_ms = 10'(`BSC_ALIGN_UNIT_MS * n_ta);
  assign accel = 8'(`BSC_ACC_BASE - `BSC_ACC_STEP * n_ta);
  assign handoff_mhz = 18'(`BSC_HO_UNIT_MHZ * n_ho);
  assign ms_tick = (ms_div_q == 16'(MS_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div_q <= 16'h0;
    end else if (clk_en) begin
      if (state_q == BSC_STANDBY || ms_tick) begin
        ms_div_q <= 16'h0;
      end else begin
        ms_div_q <= ms_div_q + 16'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= BSC_STANDBY;
      dir_q <= 1'b0;
      ms_q <= 10'h0;
      freq_q <= 18'h0;
    end else if (clk_en) begin
      if (standby_req) begin
        state_q <= BSC_STANDBY;
      end else begin
        case (state_q)
          BSC_STANDBY: begin
            state_q <= BSC_ALIGN;
            dir_q <= dir_sync_q[1];
            ms_q <= 10'h0;
            freq_q <= 18'h0;
          end
          BSC_ALIGN: begin
            if (ms_tick) begin
              ms_q <= ms_q + 10'h1;
            end
            if (ms_tick && ms_q + 10'h1 >= align_ms) begin
              state_q <= BSC_OPEN;
            end
          end
          BSC_OPEN: begin
            if (freq_q >= handoff_mhz) begin
              state_q <= BSC_CLOSED;
            end else if (ms_tick) begin
              freq_q <= freq_q + {10'h0, accel};
            end
          end
          default: begin
            state_q <= BSC_CLOSED;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Commutation angle
  // ****************************************************************
  logic [28:0] ang_acc_q;
  logic [29:0] ang_sum;
  logic ol_adv;
  logic adv;
  logic [6:0] step_q;

  assign ang_sum = {1'b0, ang_acc_q} + {12'h0, freq_q};
  assign ol_adv = (state_q == BSC_OPEN) && (ang_sum >= {1'b0, STEP_MAX});
  assign adv = ol_adv || (state_q == BSC_CLOSED && cl_step);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ang_acc_q <= 29'h0;
    end else if (clk_en) begin
      if (state_q != BSC_OPEN) begin
        ang_acc_q <= 29'h0;
      end else if (ol_adv) begin
        ang_acc_q <= 29'(ang_sum - {1'b0, STEP_MAX});
      end else begin
        ang_acc_q <= ang_sum[28:0];
      end
    end
  end

  // Rising angle gives U, V, W; falling angle gives U, W, V.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= `BSC_ALIGN_STEP;
    end else if (clk_en) begin
      if (state_q == BSC_STANDBY || state_q == BSC_ALIGN) begin
        step_q <= `BSC_ALIGN_STEP;
      end else if (adv && dir_q) begin
        step_q <= (step_q == STEPS - 7'h1) ? 7'h0 : step_q + 7'h1;
      end else if (adv) begin
        step_q <= (step_q == 7'h0) ? STEPS - 7'h1 : step_q - 7'h1;
      end
    end
  end

  // ****************************************************************
  // Phase waveform
  // ****************************************************************
  // Sine minus the lowest of the three phases: the low phase sits at
  // zero, so only one switch per leg needs to move at any time.
  function automatic logic [7:0] bsc_wave(input logic [6:0] s);
    logic [6:0] t;
    logic [6:0] a;
    t = (s >= STEPS - 7'(`BSC_SECTOR)) ?
        s - (STEPS - 7'(`BSC_SECTOR)) : s + 7'(`BSC_SECTOR);
    a = 7'h0;
    if (t < 7'(`BSC_THIRD)) begin
      a = t;
    end else if (t < 7'(2 * `BSC_THIRD)) begin
      a = t - 7'(`BSC_THIRD / 2);
    end
    if (a > 7'd24) begin
      a = 7'd48 - a;
    end
    bsc_wave = (t >= 7'(2 * `BSC_THIRD)) ? 8'h0 : BSC_SINE[a[4:0]];
  endfunction

  logic [6:0] step_v;
  logic [6:0] step_w;
  logic [7:0] g_u;
  logic [7:0] g_v;
  logic [7:0] g_w;
  logic [8:0] amp;

  assign step_v = (step_q >= 7'(`BSC_THIRD)) ?
                  step_q - 7'(`BSC_THIRD) : step_q + 7'(2 * `BSC_THIRD);
  assign step_w = (step_q >= 7'(2 * `BSC_THIRD)) ?
                  step_q - 7'(2 * `BSC_THIRD) : step_q + 7'(`BSC_THIRD);

  always_comb begin
    if (state_q == BSC_ALIGN) begin
      g_u = 8'h0;
      g_v = 8'hff;
      g_w = 8'hff;
    end else begin
      g_u = bsc_wave(step_q);
      g_v = bsc_wave(step_v);
      g_w = bsc_wave(step_w);
    end
    if (state_q == BSC_CLOSED) begin
      amp = run_amp;
    end else begin
      amp = band_amp;
    end
  end

  // Full scale is 255 by 511, close enough to 2^17 that a shift is used;
  // the top duty is about 0.6 percent short of a solid high.
  function automatic logic [10:0] bsc_cmp(input logic [7:0] g,
                                          input logic [8:0] a);
    logic [21:0] p;
    p = {14'h0, g} * {13'h0, a} * 22'd25;
    bsc_cmp = p[21:11];
  endfunction

  // ****************************************************************
  // Output PWM
  // ****************************************************************
  logic [10:0] pwm_cnt_q;
  logic [10:0] cmp_u_q;
  logic [10:0] cmp_v_q;
  logic [10:0] cmp_w_q;
  logic wrap;

  assign wrap = (pwm_cnt_q == PERIOD - 11'h1);

  // Compare values load only at the period edge so no pulse is split.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_cnt_q <= 11'h0;
      cmp_u_q <= 11'h0;
      cmp_v_q <= 11'h0;
      cmp_w_q <= 11'h0;
    end else if (clk_en) begin
      pwm_cnt_q <= wrap ? 11'h0 : pwm_cnt_q + 11'h1;
      if (wrap) begin
        cmp_u_q <= bsc_cmp(g_u, amp);
        cmp_v_q <= bsc_cmp(g_v, amp);
        cmp_w_q <= bsc_cmp(g_w, amp);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_pwm <= '0;
      phase_drive_en <= 1'b0;
    end else if (clk_en) begin
      phase_drive_en <= (state_q != BSC_STANDBY) && !standby_req;
      // Blanking on the request keeps the pins quiet as the enable drops.
      if (state_q == BSC_STANDBY || standby_req) begin
        phase_pwm <= '0;
      end else begin
        phase_pwm.u <= pwm_cnt_q < cmp_u_q;
        phase_pwm.v <= pwm_cnt_q < cmp_v_q;
        phase_pwm.w <= pwm_cnt_q < cmp_w_q;
      end
    end
  end

endmodule

`default_nettype wire

// >>> include/bsc_consts.svh
// Constants for the fan motor command and spin-up block.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define BSC_CLK_HZ 40000000
`define BSC_PWM_OUT_HZ 25000
`define BSC_PWM_PERIOD (`BSC_CLK_HZ / `BSC_PWM_OUT_HZ)
`define BSC_TAU_MS 80
`define BSC_FILT_SHIFT 6
`define BSC_MEAS_SAMPLES 512
`define BSC_SAMPLE_DIV \
  ((`BSC_TAU_MS * (`BSC_CLK_HZ / 1000)) / \
   (`BSC_MEAS_SAMPLES << `BSC_FILT_SHIFT))
`define BSC_MS_CYCLES (`BSC_CLK_HZ / 1000)
`define BSC_STEPS 96
`define BSC_STEP_ACC_MAX \
  ((64'(`BSC_CLK_HZ) * 64'd1000) / 64'(`BSC_STEPS))

// ****************************************************************
// Register map
// ****************************************************************
`define BSC_OFF_CONFIG 8'h00
`define BSC_OFF_STATUS 8'h04
`define BSC_OFF_FREQ 8'h08
`define BSC_CFG_MIN_LSB 0
`define BSC_CFG_HO_LSB 4
`define BSC_CFG_TA_LSB 8
`define BSC_CFG_RESET 32'h0000_0f10
`define BSC_ST_DIR_BIT 18
`define BSC_ST_STATE_LSB 16

// ****************************************************************
// Command thresholds on the 0..511 scale
// ****************************************************************
`define BSC_STBY_TH 9'h008
`define BSC_MIN_5 9'h01a
`define BSC_MIN_10 9'h034
`define BSC_MIN_13 9'h043
`define BSC_OL_43 9'h0dc
`define BSC_OL_50 9'h100
`define BSC_OL_60 9'h133
`define BSC_OL_75 9'h17f
`define BSC_OL_100 9'h1ff

// ****************************************************************
// Start-up profile
// ****************************************************************
`define BSC_HO_UNIT_MHZ 12500
`define BSC_ALIGN_UNIT_MS 40
`define BSC_ACC_BASE 160
`define BSC_ACC_STEP 10
`define BSC_ALIGN_STEP 7'h48
`define BSC_SECTOR 8
`define BSC_THIRD 32

`endif

// >>> include/bsc_pkg.sv
// Types shared by the fan motor command and spin-up block.
package bsc_pkg;

  typedef enum logic [1:0] {
    BSC_STANDBY = 2'b00,
    BSC_ALIGN = 2'b01,
    BSC_OPEN = 2'b10,
    BSC_CLOSED = 2'b11
  } bsc_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } bsc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } bsc_apb_rsp_s;

  typedef struct packed {
    logic u;
    logic v;
    logic w;
  } bsc_phase_s;

  typedef logic [7:0] bsc_sine_t [0:24];

  // Quarter sine, 3.75 degree steps, full scale 255.
  localparam bsc_sine_t BSC_SINE = '{
    8'h00, 8'h11, 8'h21, 8'h32, 8'h42, 8'h52, 8'h62, 8'h71, 8'h80,
    8'h8e, 8'h9b, 8'ha8, 8'hb4, 8'hc0, 8'hca, 8'hd4, 8'hdd, 8'he5,
    8'hec, 8'hf1, 8'hf6, 8'hfa, 8'hfd, 8'hfe, 8'hff};

endpackage

// >>> sim/bsc_host_model.sv
// Host speed source that drives the speed pin at a fixed 50 kHz.
`timescale 1ns/1ps
`default_nettype none
module bsc_host_model #(
  parameter int PERIOD = 800
) (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // High time in clock cycles per period.
  input wire logic [9:0] high_cnt,
  // Speed pin.
  output logic speed_pwm
);
  logic [9:0] cnt_q;
  // The rate sits inside the accepted input range, so no aliasing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= (cnt_q == 10'(PERIOD - 1)) ? 10'h000 : cnt_q + 10'h001;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_pwm <= 1'b0;
    end else begin
      speed_pwm <= cnt_q < high_cnt;
    end
  end
endmodule
`default_nettype wire

// >>> sim/bsc_spinup_checker.sv
// Port checker of the fan motor spin-up block, bound into the design.
`timescale 1ns/1ps
`default_nettype none
module bsc_spinup_checker (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Register bus.
  input wire bsc_pkg::bsc_apb_req_s apb_req,
  input wire bsc_pkg::bsc_apb_rsp_s apb_rsp,
  // Motor phases.
  input wire bsc_pkg::bsc_phase_s phase_pwm,
  input wire logic phase_drive_en
);
  import bsc_pkg::*;
  // ****
  // Helpers
  // ****
  logic setup;
  logic mapped;
  logic rise;
  logic u_q;
  logic seen_q;
  logic [15:0] gap_q;
  assign setup = apb_req.psel && !apb_req.penable;
  assign mapped = apb_req.paddr inside {8'h00, 8'h04, 8'h08};
  assign rise = phase_pwm.u && !u_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      u_q <= 1'b0;
    end else begin
      u_q <= phase_pwm.u;
    end
  end
  // Gaps are judged modulo the period, since a phase may skip whole periods.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (!phase_drive_en) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b0;
    end else if (rise) begin
      gap_q <= 16'h0000;
      seen_q <= 1'b1;
    end else if (gap_q != 16'hffff) begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_bus_ready:
    assert property (apb_req.psel |-> apb_rsp.pready)
    else $error("pready low in a transfer");
  a_unmapped_err:
    assert property (setup && !mapped |=>
      apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ro_write_err:
    assert property (setup && apb_req.pwrite && apb_req.paddr != 8'h00
      |=> apb_rsp.pslverr)
    else $error("read-only write not refused");
  a_good_no_err:
    assert property (setup && mapped &&
      (!apb_req.pwrite || apb_req.paddr == 8'h00) |=> !apb_rsp.pslverr)
    else $error("legal access refused");
  a_rsp_holds:
    assert property (!setup |=>
      $stable(apb_rsp.prdata) && $stable(apb_rsp.pslverr))
    else $error("response moved outside setup");
  a_cfg_spare_zero:
    assert property (setup && !apb_req.pwrite && apb_req.paddr == 8'h00
      |=> apb_rsp.prdata[31:12] == 20'h0 && apb_rsp.prdata[3:2] == 2'h0)
    else $error("config spare bits set");
  a_status_spare_zero:
    assert property (setup && !apb_req.pwrite && apb_req.paddr == 8'h04
      |=> apb_rsp.prdata[31:19] == 13'h0 && apb_rsp.prdata[15:9] == 7'h0)
    else $error("status spare bits set");
  a_idle_quiet:
    assert property (!phase_drive_en |-> phase_pwm == 3'b000)
    else $error("phases active while undriven");
  a_one_low:
    assert property (phase_drive_en |->
      !(phase_pwm.u && phase_pwm.v && phase_pwm.w))
    else $error("no phase held low");
  a_pwm_period:
    assert property (rise && seen_q |->
      (gap_q % 16'h0640) == 16'h063f || gap_q == 16'hffff)
    else $error("phase period not 1600 cycles");
endmodule
bind bsc_spinup bsc_spinup_checker i_chk (
  .pclk(pclk),
  .presetn(presetn),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .phase_pwm(phase_pwm),
  .phase_drive_en(phase_drive_en)
);
`default_nettype wire

// >>> sim/bsc_spinup_tb_top.sv
// Self-checking bench of the fan motor spin-up block.
`timescale 1ns/1ps
`default_nettype none
module bsc_spinup_tb_top;
  import bsc_pkg::*;
  localparam int MS = 40;
  logic pclk;
  logic presetn;
  bsc_apb_req_s apb_req;
  bsc_apb_rsp_s apb_rsp;
  bsc_phase_s phase_pwm;
  logic phase_drive_en;
  logic speed_pwm;
  logic direction_select;
  logic cl_step;
  logic [2:0] vcc_band;
  logic [9:0] high_cnt;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic err;
  logic in_align;
  logic al_bad;
  int num_errors, check_count, seed, t0, ta, n, h, acc, c0, f, k, d;
  int cyc = 0;
  bsc_spinup #(.MS_CYCLES(MS), .SAMPLE_DIV(1)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1),
    .apb_req(apb_req), .apb_rsp(apb_rsp),
    .speed_pwm(speed_pwm), .direction_select(direction_select),
    .vcc_band(vcc_band), .cl_step(cl_step),
    .phase_pwm(phase_pwm), .phase_drive_en(phase_drive_en));
  bsc_host_model i_host (.pclk(pclk), .presetn(presetn),
    .high_cnt(high_cnt), .speed_pwm(speed_pwm));
  // ****
  // Clock, watchers and tasks
  // ****
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  // The first period after entry may still carry the old waveform.
  always @(posedge pclk) begin
    if (in_align && cyc > ta + 1700 && phase_drive_en) begin
      if (phase_pwm.u !== 1'b0 || phase_pwm.v !== phase_pwm.w) al_bad <= 1'b1;
    end
  end
  task automatic results;
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo;
    num_errors++;
    results();
  endtask
  task automatic chk(input string name, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int j;
    j = 0;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      j++;
    end while (apb_rsp.pready !== 1'b1 && j < 16);
    if (apb_rsp.pready !== 1'b1) tmo();
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask
  task automatic wait_state(input logic [1:0] s, input int bound);
    int j;
    j = 0;
    do begin
      apb(1'b0, 8'h04, 32'h0);
      j++;
    end while (rd[17:16] !== s && j < bound);
    if (rd[17:16] !== s) tmo();
  endtask
  function automatic int exp_cmd(input int c, input int w);
    real x;
    x = c;
    repeat (w) x = x + (511.0 - x) / 64.0;
    return int'(x);
  endfunction
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'hbebfabeb;
    apb_req = '0;
    presetn = 1'b0;
    direction_select = 1'b0;
    vcc_band = 3'h0;
    cl_step = 1'b0;
    high_cnt = 10'h000;
    in_align = 1'b0;
    al_bad = 1'b0;
    num_errors = 0;
    check_count = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk("config reset", rd, 32'h0000_0f10);
    apb(1'b0, 8'h0c, 32'h0);
    chk("unmapped err", err, 32'h1);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    chk("status write err", err, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk("reset state", rd[17:16], 32'h0);
    // Read-back over every minimum duty code.
    for (int i = 0; i < 4; i++) begin
      n = 2 + ($unsigned($random(seed)) % 2);
      h = 1 + ($unsigned($random(seed)) % 2);
      cfg = {20'h0, 4'(n), 4'(h), 2'h0, 2'(i)};
      apb(1'b1, 8'h00, cfg);
      apb(1'b0, 8'h00, 32'h0);
      chk("config", rd, cfg);
    end
    // The first start uses the slowest, longest setting.
    apb(1'b1, 8'h00, {20'h0, 4'hf, cfg[7:0]});
    acc = 160 - 10 * n;
    direction_select <= 1'($random(seed));
    vcc_band <= 3'($unsigned($random(seed)) % 5);
    high_cnt <= 10'd800;
    wait_state(2'b01, 1000);
    chk("direction", rd[18], direction_select);
    high_cnt <= 10'h000;
    wait_state(2'b00, 20000);
    repeat (2) @(posedge pclk);
    chk("drive off", phase_drive_en, 32'h0);
    c0 = rd[8:0];
    apb(1'b1, 8'h00, cfg);
    direction_select <= ~direction_select;
    high_cnt <= 10'd800;
    t0 = cyc;
    wait_state(2'b01, 1000);
    chk("direction", rd[18], direction_select);
    ta = cyc;
    in_align = 1'b1;
    wait_state(2'b10, 3000);
    in_align = 1'b0;
    d = cyc - ta - 40 * n * MS;
    chk("align time", 32'(d <= 8 && d >= -8), 32'h1);
    chk("align pattern", al_bad, 32'h0);
    chk("drive on", phase_drive_en, 32'h1);
    ta = cyc;
    k = 0;
    do begin
      apb(1'b0, 8'h08, 32'h0);
      f = rd;
      apb(1'b0, 8'h04, 32'h0);
      if (rd[17:16] == 2'b10) begin
        chk("freq step", f % acc, 32'h0);
        chk("freq limit", 32'(f < 12500 * h), 32'h1);
      end
      k++;
    end while (rd[17:16] !== 2'b11 && k < 3000);
    if (rd[17:16] !== 2'b11) tmo();
    d = cyc - ta - MS * ((12500 * h + acc - 1) / acc);
    chk("open time", 32'(d <= 50 && d >= -50), 32'h1);
    repeat (300) begin
      @(posedge pclk);
      cl_step <= 1'($random(seed));
    end
    cl_step <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk("closed state", rd[17:16], 32'h3);
    chk("closed drive", phase_drive_en, 32'h1);
    while (cyc < t0 + 64 * 512) @(posedge pclk);
    apb(1'b0, 8'h04, 32'h0);
    d = int'(rd[8:0]) - exp_cmd(c0, 64);
    chk("filtered command", 32'(d <= 8 && d >= -8), 32'h1);
    results();
  end
endmodule
`default_nettype wire
